// ==== core/iicsf_flag.sv ====
// Purpose: bank of sticky flags, write one to clear
// Assumes: set and clear are synchronous to clk_in; set terms may be levels held for many cycles
// Notes:   a set in the clearing cycle wins, so no event is lost
`timescale 1ns/1ps
`default_nettype none
module iicsf_flag #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // control
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  output var  logic [W-1:0] q_out
);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_out <= '0;
    end else begin
      q_out <= (q_out & ~clr_in) | set_in; // R19
    end
  end
endmodule : iicsf_flag
`default_nettype wire

// ==== core/iicsf_pkg.sv ====
// Purpose: shared constants and carrier types for the iic status flags
// Assumes: 32-bit apb data, flags packed into bits 31..24
// Notes:   offsets are byte addresses inside a 4 kbyte window
package iicsf_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W   = 12;
  localparam logic [11:0] OFS_ISR  = 12'h020;
  localparam logic [11:0] OFS_IER  = 12'h028;
  localparam logic [11:0] OFS_CR   = 12'h100;
  localparam logic [11:0] OFS_SR   = 12'h104;
  localparam logic [11:0] OFS_ADR  = 12'h110;
  localparam logic [11:0] OFS_TBA  = 12'h11c;
  localparam logic [11:0] OFS_RXTH = 12'h120;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FLD_LO   = 24;
  localparam int FLD_W    = 8;
  localparam int CR_EN    = 31;
  localparam int CR_GC    = 25;
  localparam int ADR_LO   = 1;
  localparam int ADR_W    = 7;
  localparam int TBA_W    = 10;
  localparam int TBA_MODE = 15;
  localparam int RXTH_W   = 4;
  // ---------------------------------------------------------------
  // reset values and bus constants
  // ---------------------------------------------------------------
  localparam logic [7:0]  FLD_RST  = 8'h00;
  localparam logic [6:0]  ADR_RST  = 7'h00;
  localparam logic [10:0] TBA_RST  = 11'h000;
  localparam logic [3:0]  RXTH_RST = 4'h0;
  localparam logic [31:0] WORD_0   = 32'h0000_0000;
  localparam logic [6:0]  GC_ADDR  = 7'h00;
  localparam logic [4:0]  TEN_PFX  = 5'h1e;
  localparam logic [3:0]  BIT_LAST = 4'h7;
  localparam logic [3:0]  BIT_ACK  = 4'h8;
  localparam int          Q_DEPTH  = 16;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR1,
    ST_ADDR2,
    ST_DATA
  } iicsf_state_t;

  // status bits 31 down to 24
  typedef struct packed {
    logic general_call_hit;
    logic addressed_slave_flag;
    logic bus_busy_flag;
    logic slave_direction_bit;
    logic tx_queue_full;
    logic rx_queue_full_status;
    logic rx_queue_empty_status;
    logic tx_queue_empty;
  } iicsf_status_t;

  // interrupt bits 31 down to 24
  typedef struct packed {
    logic arbitration_lost_irq;
    logic tx_error_or_slave_tx_done;
    logic tx_queue_empty_irq;
    logic rx_queue_full_irq;
    logic bus_idle_irq;
    logic addressed_irq;
    logic not_addressed_irq;
    logic tx_queue_half_empty_irq;
  } iicsf_irq_t;
endpackage : iicsf_pkg

// ==== core/iicsf_sync.sv ====
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are slow levels relative to clk_in
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module iicsf_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // levels
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '1;
      q_out  <= '1;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule : iicsf_sync
`default_nettype wire

// ==== core/iicsf_top.sv ====
// Purpose: status and interrupt flags of a master/slave iic controller
// Assumes: queue levels and error pulses come from logic on clk_sys_in
// Notes:   one wait state on every apb access
//
// Summary of operation
// [R1] core enable gates all other control bits
// [R2] status register clears on reset
// [R3] status bit 24 shows transmit queue empty
// [R4] status bit 25 shows receive queue empty
// [R5] bit 26 only at sixteen entries, threshold ignored
// [R6] status bit 27 shows transmit queue full
// [R7] bit 28 holds master direction when addressed
// [R8] bit 29 set on start, cleared on stop
// [R9] own address match sets bit 30, slave mode
// [R10] ten-bit mode: ten-bit match or general call
// [R11] bit 30 clears on stop or repeated start
// [R12] bit 31 set on enabled general call
// [R13] irq 24 half empty, irq 29 empty
// [R14] irq 25 unaddressed, 26 addressed, 27 idle
// [R15] irq 28 rx full, 30 error, 31 arbitration
// [R16] eeprom answers only control code 1010
// [R17] eeprom ignores two block bits, uses lowest
// [R18] eeprom takes byte or sixteen-byte page writes
// [R19] interrupt flags sticky until written one
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module iicsf_top #(
  parameter int DEPTH = iicsf_pkg::Q_DEPTH,
  parameter int LVL_W = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  wire logic                    clk_sys_in,
  input  wire logic                    rst_in,
  // apb slave
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [iicsf_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]             pwdata_in,
  output var  logic [31:0]             prdata_out,
  output var  logic                    pready_out,
  output var  logic                    pslverr_out,
  // queue levels and events
  input  wire logic [LVL_W-1:0]        tx_level_in,
  input  wire logic [LVL_W-1:0]        rx_level_in,
  input  wire logic                    tx_error_in,
  input  wire logic                    slave_tx_done_in,
  input  wire logic                    arb_lost_in,
  // iic pins
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  // outputs
  output var  logic                    irq_out,
  output var  logic                    slave_mode_out
);
  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);
  localparam logic [LVL_W-1:0] LVL_HALF = LVL_W'(DEPTH / 2);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [1:0]                    pin_s;
  logic                          scl_s, sda_s, scl_q, sda_q;
  logic                          start_det, stop_det, scl_rise;
  logic [7:0]                    cr_r, ier_r;
  logic [iicsf_pkg::ADR_W-1:0]   adr_r;
  logic [10:0]                   tba_r;
  logic [iicsf_pkg::RXTH_W-1:0]  rxth_r;
  logic                          cr_en, gc_en, ten_mode;
  iicsf_pkg::iicsf_state_t       st_r;
  logic [3:0]                    cnt_r;
  logic [7:0]                    shf_r, byte_w;
  logic                          at_last, hit7, hit10, hit_gc, pfx10;
  logic                          rw1_r, aas_r, srw_r, general_call_hit_r, bb_r;
  logic                          sr_txe_r, sr_rxe_r, sr_rxf_r, sr_txf_r;
  iicsf_pkg::iicsf_status_t      sr_w;
  iicsf_pkg::iicsf_irq_t         ev_w;
  logic [7:0]                    ev_bits, isr_q, isr_clr_w, keep_w;
  logic                          req_w, acc_w, wr_w, hit_w;
  logic [31:0]                   rd_w;

  // ---------------------------------------------------------------
  // pin synchronisation and bus conditions
  // ---------------------------------------------------------------
  iicsf_sync #(.W(2)) u_sync (
    .clk_in (clk_sys_in),
    .rst_in (rst_in),
    .d_in   ({scl_in, sda_in}),
    .q_out  (pin_s)
  );
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  // sda moving while scl stays high marks start and stop
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  assign scl_rise  = scl_s & ~scl_q;

  // ---------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------
  assign cr_en    = cr_r[iicsf_pkg::CR_EN - iicsf_pkg::FLD_LO]; // R1
  assign gc_en    = cr_en & cr_r[iicsf_pkg::CR_GC - iicsf_pkg::FLD_LO]; // R1
  assign ten_mode = tba_r[iicsf_pkg::TBA_W];
  // ---------------------------------------------------------------
  // address phase tracking
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      shf_r <= 8'h00;
    end else if (scl_rise) begin
      shf_r <= byte_w;
    end
  end
  assign byte_w  = {shf_r[6:0], sda_s};
  assign at_last = scl_rise & (cnt_r == iicsf_pkg::BIT_LAST) & cr_en;
  assign pfx10   = ten_mode &
                   (byte_w[7:3] == iicsf_pkg::TEN_PFX) &
                   (byte_w[2:1] == tba_r[9:8]);
  assign hit_gc  = at_last & (st_r == iicsf_pkg::ST_ADDR1) & gc_en &
                   (byte_w[7:1] == iicsf_pkg::GC_ADDR); // R12
  assign hit7    = at_last & (st_r == iicsf_pkg::ST_ADDR1) & ~ten_mode &
                   (byte_w[7:1] == adr_r); // R9
  assign hit10   = at_last & (st_r == iicsf_pkg::ST_ADDR2) &
                   (byte_w == tba_r[7:0]); // R10
  // the ack clock of the first byte rolls the count into the second
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_r  <= iicsf_pkg::ST_IDLE;
      cnt_r <= 4'h0;
    end else if (start_det) begin
      st_r  <= iicsf_pkg::ST_ADDR1;
      cnt_r <= 4'h0;
    end else if (stop_det) begin
      st_r  <= iicsf_pkg::ST_IDLE;
    end else if (scl_rise && st_r != iicsf_pkg::ST_IDLE) begin
      cnt_r <= (cnt_r == iicsf_pkg::BIT_ACK) ? 4'h0 : cnt_r + 4'h1;
      if (cnt_r == iicsf_pkg::BIT_LAST) begin
        case (st_r)
          iicsf_pkg::ST_ADDR1: begin
            st_r <= (pfx10 && cr_en) ? iicsf_pkg::ST_ADDR2
                                     : iicsf_pkg::ST_DATA; // R10
          end
          default: begin
            st_r <= iicsf_pkg::ST_DATA;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rw1_r <= 1'b0;
    end else if (at_last && st_r == iicsf_pkg::ST_ADDR1) begin
      rw1_r <= byte_w[0];
    end
  end

  // ---------------------------------------------------------------
  // bus state flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bb_r <= 1'b0; // R2
    end else if (start_det) begin
      bb_r <= 1'b1; // R8
    end else if (stop_det) begin
      bb_r <= 1'b0; // R8
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      aas_r  <= 1'b0; // R2
      general_call_hit_r <= 1'b0;
    end else if (start_det || stop_det) begin
      aas_r  <= 1'b0; // R11
      general_call_hit_r <= 1'b0;
    end else begin
      if (hit7 || hit10 || hit_gc) begin
        aas_r <= 1'b1; // R9
      end
      if (hit_gc) begin
        general_call_hit_r <= 1'b1; // R12
      end
    end
  end

  // direction only means something once the address byte is done
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      srw_r <= 1'b0; // R2
    end else if (hit10) begin
      srw_r <= rw1_r; // R7
    end else if (hit7 || hit_gc) begin
      srw_r <= byte_w[0]; // R7
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sr_txe_r <= 1'b0; // R2
      sr_rxe_r <= 1'b0;
      sr_rxf_r <= 1'b0;
      sr_txf_r <= 1'b0;
    end else begin
      sr_txe_r <= (tx_level_in == '0); // R3
      sr_rxe_r <= (rx_level_in == '0); // R4
      sr_rxf_r <= (rx_level_in == LVL_FULL); // R5
      sr_txf_r <= (tx_level_in == LVL_FULL); // R6
    end
  end

  assign sr_w = {general_call_hit_r, aas_r, bb_r, srw_r,
                 sr_txf_r, sr_rxf_r, sr_rxe_r, sr_txe_r};

  // ---------------------------------------------------------------
  // interrupt flags
  // ---------------------------------------------------------------
  always_comb begin
    ev_w.tx_queue_half_empty_irq   = (tx_level_in <= LVL_HALF); // R13
    ev_w.tx_queue_empty_irq        = sr_txe_r; // R13
    ev_w.not_addressed_irq         = ~aas_r; // R14
    ev_w.addressed_irq             = aas_r; // R14
    ev_w.bus_idle_irq              = ~bb_r; // R14
    ev_w.rx_queue_full_irq         = sr_rxf_r; // R15
    ev_w.tx_error_or_slave_tx_done = tx_error_in | slave_tx_done_in; // R15
    ev_w.arbitration_lost_irq      = arb_lost_in; // R15
  end

  assign ev_bits   = ev_w;
  assign isr_clr_w = (wr_w && paddr_in == iicsf_pkg::OFS_ISR)
                   ? pwdata_in[31:iicsf_pkg::FLD_LO] : 8'h00;
  assign keep_w    = isr_q & ~isr_clr_w;
  iicsf_flag #(.W(iicsf_pkg::FLD_W)) u_isr (
    .clk_in (clk_sys_in),
    .rst_in (rst_in),
    .set_in (ev_bits),
    .clr_in (isr_clr_w),
    .q_out  (isr_q)
  );
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(isr_q & ier_r);
    end
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      slave_mode_out <= 1'b0;
    end else begin
      slave_mode_out <= aas_r & ~(start_det | stop_det); // R9
    end
  end

  // ---------------------------------------------------------------
  // apb slave, one wait state so read data comes from a flop
  // ---------------------------------------------------------------
  assign req_w = psel_in & penable_in & ~pready_out;
  assign acc_w = psel_in & penable_in & pready_out;
  assign wr_w  = acc_w & pwrite_in;

  always_comb begin
    rd_w  = iicsf_pkg::WORD_0;
    hit_w = 1'b1;
    case (paddr_in)
      iicsf_pkg::OFS_ISR:  rd_w[31:iicsf_pkg::FLD_LO] = isr_q;
      iicsf_pkg::OFS_IER:  rd_w[31:iicsf_pkg::FLD_LO] = ier_r;
      iicsf_pkg::OFS_CR:   rd_w[31:iicsf_pkg::FLD_LO] = cr_r;
      iicsf_pkg::OFS_SR:   rd_w[31:iicsf_pkg::FLD_LO] = sr_w;
      iicsf_pkg::OFS_ADR:  rd_w[7:iicsf_pkg::ADR_LO] = adr_r;
      iicsf_pkg::OFS_TBA: begin
        rd_w[iicsf_pkg::TBA_W-1:0] = tba_r[9:0];
        rd_w[iicsf_pkg::TBA_MODE]  = tba_r[iicsf_pkg::TBA_W];
      end
      iicsf_pkg::OFS_RXTH: rd_w[iicsf_pkg::RXTH_W-1:0] = rxth_r;
      default:             hit_w = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= iicsf_pkg::WORD_0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= req_w;
      prdata_out  <= req_w ? rd_w : iicsf_pkg::WORD_0;
      pslverr_out <= req_w & ~hit_w;
    end
  end

  // threshold is stored only; it never moves the full flag
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cr_r   <= iicsf_pkg::FLD_RST;
      ier_r  <= iicsf_pkg::FLD_RST;
      adr_r  <= iicsf_pkg::ADR_RST;
      tba_r  <= iicsf_pkg::TBA_RST;
      rxth_r <= iicsf_pkg::RXTH_RST;
    end else if (wr_w) begin
      case (paddr_in)
        iicsf_pkg::OFS_CR:   cr_r  <= pwdata_in[31:iicsf_pkg::FLD_LO];
        iicsf_pkg::OFS_IER:  ier_r <= pwdata_in[31:iicsf_pkg::FLD_LO];
        iicsf_pkg::OFS_ADR:  adr_r <= pwdata_in[7:iicsf_pkg::ADR_LO];
        iicsf_pkg::OFS_TBA: begin
          tba_r <= {pwdata_in[iicsf_pkg::TBA_MODE],
                    pwdata_in[iicsf_pkg::TBA_W-1:0]};
        end
        iicsf_pkg::OFS_RXTH: rxth_r <= pwdata_in[iicsf_pkg::RXTH_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_txe_track: assert property ( // R3
    (tx_level_in == '0) && !rst_in |=> sr_txe_r)
    else $error("tx empty flag missed");
  a_rxe_track: assert property ( // R4
    !rst_in |=> sr_rxe_r == $past(rx_level_in == '0))
    else $error("rx empty flag wrong");
  a_rxf_depth: assert property ( // R5
    (rx_level_in != LVL_FULL) |=> !sr_rxf_r)
    else $error("rx full below sixteen");
  a_txf_full: assert property ( // R6
    !rst_in |=> sr_txf_r == $past(tx_level_in == LVL_FULL))
    else $error("tx full flag wrong");
  a_bb_start: assert property ( // R8
    start_det |=> bb_r ##1 (bb_r || $past(stop_det)))
    else $error("busy not held after start");
  a_bb_stop: assert property ( // R8
    stop_det |=> !bb_r)
    else $error("busy not cleared on stop");
  a_aas_clear: assert property ( // R11
    (start_det || stop_det) |=> !aas_r && !general_call_hit_r)
    else $error("addressed flag kept over start or stop");
  a_aas_hit: assert property ( // R9
    hit7 |=> aas_r && srw_r == $past(sda_s) ##1 slave_mode_out)
    else $error("own address not taken");
  a_en_gate: assert property ( // R1
    (!cr_en && !aas_r) |=> !aas_r)
    else $error("addressed while disabled");
  a_gc_gate: assert property ( // R12
    (!gc_en && !general_call_hit_r) |=> !general_call_hit_r)
    else $error("general call without enable");
  a_isr_hold: assert property ( // R19
    (keep_w != '0) |=> (isr_q & $past(keep_w)) == $past(keep_w))
    else $error("interrupt flag lost");
  a_isr_set: assert property ( // R13
    !rst_in |=> (isr_q & $past(ev_bits)) == $past(ev_bits))
    else $error("interrupt event not latched");
endmodule : iicsf_top
`default_nettype wire

// ==== testbench/iicsf_bus_model.sv ====
// Purpose: iic master model on the far side of the flag block
// Assumes: pull-ups on both lines; the block never drives them
// Notes:   scl stands high between frames; 800 ns bit period
`timescale 1ns/1ps
`default_nettype none
module iicsf_bus_model (
  // bus levels
  output var logic scl_out,
  output var logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // ------------
  // bus actions
  // ------------
  // start or repeated start; the offset keeps edges off the clock
  task automatic start_cond();
    #30;
    sda_out = 1'b1;
    #200;
    scl_out = 1'b1;
    #200;
    sda_out = 1'b0;
    #400;
    scl_out = 1'b0;
    #200;
  endtask : start_cond
  // msb first; ninth bit released, so the pull-up reads a nack
  task automatic send_byte(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      sda_out = (i == 0) ? 1'b1 : b[i-1];
      #200;
      scl_out = 1'b1;
      #400;
      scl_out = 1'b0;
      #200;
    end
  endtask : send_byte
  task automatic stop_cond();
    #30;
    sda_out = 1'b0;
    #200;
    scl_out = 1'b1;
    #200;
    sda_out = 1'b1;
    #400;
  endtask : stop_cond
endmodule : iicsf_bus_model
`default_nettype wire

// ==== testbench/tb_iic_status_interrupt_flags.sv ====
// Purpose: self-checking bench for the iic status and interrupt flags
// Assumes: apb slave with one wait state; master model on the pins
// Notes:   flags clear by writing one, as the design hands it over
`timescale 1ns/1ps
`default_nettype none
module tb_iic_status_interrupt_flags;
  // ------------
  // signals
  // ------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [4:0]  tx_lvl = 5'h00;
  logic [4:0]  rx_lvl = 5'h00;
  logic [2:0]  evt = 3'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl;
  logic        sda;
  logic        irq;
  logic        slv;
  logic [31:0] rdat;
  logic        rerr;
  int          errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  always #50 clk = ~clk;
  iicsf_top i_dut (
    .clk_sys_in(clk), .rst_in(rst),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .tx_level_in(tx_lvl), .rx_level_in(rx_lvl),
    .tx_error_in(evt[0]), .slave_tx_done_in(evt[1]),
    .arb_lost_in(evt[2]), .scl_in(scl), .sda_in(sda),
    .irq_out(irq), .slave_mode_out(slv)
  );
  iicsf_bus_model i_bus (.scl_out(scl), .sda_out(sda));
  // ------------
  // helpers
  // ------------
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, e, input string m);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a,
                        input logic [31:0] m, e, input string s);
    apb(1'b0, a, 32'h0);
    chk(rdat & m, e, s);
  endtask : rd_chk
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= 3'h0;
  endtask : pulse
  task automatic frame(input logic [7:0] b);
    i_bus.start_cond();
    i_bus.send_byte(b);
  endtask : frame
  // ------------
  // scenarios
  // ------------
  task automatic t_levels();
    logic [13:0] tab [4] = '{14'h0003, 14'h210c, 14'h12f0, 14'h0105};
    apb(1'b1, iicsf_pkg::OFS_RXTH, 32'h0000_000f);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      tx_lvl <= tab[i][13:9];
      rx_lvl <= tab[i][8:4];
      rd_chk(iicsf_pkg::OFS_SR, 32'h0f00_0000,
             {4'h0, tab[i][3:0], 24'h0}, "fifo bits");
    end
    rd_chk(iicsf_pkg::OFS_ISR, 32'h3100_0000, 32'h3100_0000, "q irq");
    rx_lvl <= 5'h00;
    apb(1'b1, iicsf_pkg::OFS_ISR, 32'h1000_0000);
    rd_chk(iicsf_pkg::OFS_ISR, 32'h1000_0000, 32'h0, "w1c");
  endtask : t_levels
  task automatic t_irq();
    logic [31:0] m;
    for (int k = 0; k < 3; k++) begin
      m = (k == 2) ? 32'h8000_0000 : 32'h4000_0000;
      apb(1'b1, iicsf_pkg::OFS_ISR, 32'hc000_0000);
      pulse(3'h1 << k);
      rd_chk(iicsf_pkg::OFS_ISR, 32'hc000_0000, m, "event");
      chk(irq, 32'h0, "masked irq");
      apb(1'b1, iicsf_pkg::OFS_IER, m);
      repeat (2) @(posedge clk);
      chk(irq, 32'h1, "irq high");
      apb(1'b1, iicsf_pkg::OFS_ISR, m);
      rd_chk(iicsf_pkg::OFS_ISR, 32'hc000_0000, 32'h0, "clear");
      chk(irq, 32'h0, "irq low");
      apb(1'b1, iicsf_pkg::OFS_IER, 32'h0);
    end
  endtask : t_irq
  task automatic t_slave();
    apb(1'b1, iicsf_pkg::OFS_ADR, 32'h0000_0054);
    frame(8'h55);
    rd_chk(iicsf_pkg::OFS_SR, 32'h4000_0000, 32'h0, "disabled");
    i_bus.stop_cond();
    apb(1'b1, iicsf_pkg::OFS_CR, 32'h8000_0000);
    frame(8'h55);
    rd_chk(iicsf_pkg::OFS_SR, 32'hf000_0000, 32'h7000_0000, "hit");
    chk(slv, 32'h1, "slave mode");
    rd_chk(iicsf_pkg::OFS_ISR, 32'h0400_0000, 32'h0400_0000, "as");
    i_bus.start_cond();
    rd_chk(iicsf_pkg::OFS_SR, 32'h6000_0000, 32'h2000_0000, "rs");
    // the read returns on a clock edge; keep pin edges off it
    #30;
    i_bus.send_byte(8'h54);
    rd_chk(iicsf_pkg::OFS_SR, 32'h7000_0000, 32'h6000_0000, "wr");
    i_bus.stop_cond();
    rd_chk(iicsf_pkg::OFS_SR, 32'h6000_0000, 32'h0, "stop");
    apb(1'b1, iicsf_pkg::OFS_ISR, 32'h0e00_0000);
    rd_chk(iicsf_pkg::OFS_ISR, 32'h0e00_0000, 32'h0a00_0000, "na");
  endtask : t_slave
  task automatic t_gcall();
    for (int g = 0; g < 2; g++) begin
      apb(1'b1, iicsf_pkg::OFS_CR, {6'h20, g[0], 25'h0});
      frame(8'h00);
      rd_chk(iicsf_pkg::OFS_SR, 32'h8000_0000, {g[0], 31'h0}, "gc");
      i_bus.stop_cond();
    end
  endtask : t_gcall
  // memory traffic: code 1010, block bit set, then a full page;
  // the control byte must never address this block
  task automatic t_page();
    frame(8'ha2);
    i_bus.send_byte(8'h00);
    for (int n = 0; n < 16; n++) begin
      i_bus.send_byte(n[7:0]);
    end
    rd_chk(iicsf_pkg::OFS_SR, 32'h6000_0000, 32'h2000_0000, "page");
    i_bus.stop_cond();
    rd_chk(iicsf_pkg::OFS_SR, 32'h2000_0000, 32'h0, "page end");
  endtask : t_page
  // ends in a reset mid-frame, so it runs last
  task automatic t_ten();
    apb(1'b1, iicsf_pkg::OFS_TBA, 32'h0000_82a5);
    frame(8'h55);
    rd_chk(iicsf_pkg::OFS_SR, 32'h4000_0000, 32'h0, "7 in 10");
    i_bus.stop_cond();
    frame(8'hf4);
    i_bus.send_byte(8'ha5);
    rd_chk(iicsf_pkg::OFS_SR, 32'h4000_0000, 32'h4000_0000, "10");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(iicsf_pkg::OFS_SR, 32'hffff_ffff, 32'h0300_0000, "rst");
    i_bus.stop_cond();
    apb(1'b0, 12'h0ff, 32'h0);
    chk(rdat, 32'h0, "unmapped data");
    chk({31'h0, rerr}, 32'h1, "unmapped error");
  endtask : t_ten
  // ------------
  // sequence
  // ------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_levels();
    t_irq();
    t_slave();
    t_gcall();
    t_page();
    t_ten();
    stop_test();
  end
endmodule : tb_iic_status_interrupt_flags
`default_nettype wire
